// ---- src/rrrc_top.sv ----
// ramp rate, switching frequency and restart hold-off logic for the regulators
// Function
// [R01] regulator four: 128 steps, 2-bit interval select
// [R02] regulator three: 128 steps, 2-bit interval select
// [R03] regulator two: 10 or 20 us per step
// [R04] regulator one: 10 or 20 us per step
// [R05] buck frequency: 0 is 440kHz, 1 is 2.2MHz
// [R06] buck-boost frequency: 0 is 440kHz, 1 is 2.2MHz
// [R07] buck restart waits 50, 20 or 10 ms
// [R08] buck-boost restart waits 50, 20 or 10 ms
// [R09] code 3 lets the converter restart anytime
// [R10] software keeps buck wait not below buck-boost
// [R11] reserved bits read zero, ignore writes
// [R12] ramp steps once per interval, stops at end
module rrrc_top #(
    parameter logic [15:0] HOLD_50MS_US = 16'hc350,
    parameter logic [15:0] HOLD_20MS_US = 16'h4e20,
    parameter logic [15:0] HOLD_10MS_US = 16'h2710,
    parameter logic [6:0]  TICK_DIV     = rrrc_pkg::TICK_CYCLES
) (
    input  wire logic                                clk_in,
    input  wire logic                                reset_in,
    input  wire logic [9:0]                          reg_addr_in,
    input  wire logic                                reg_wr_in,
    input  wire logic [7:0]                          reg_wdata_in,
    output logic      [7:0]                          reg_rd_data_out,
    input  wire logic [rrrc_pkg::NUM_RAMPS-1:0]      ramp_start_in,
    output logic      [rrrc_pkg::NUM_RAMPS-1:0][7:0] ramp_level_out,
    output logic      [rrrc_pkg::NUM_RAMPS-1:0]      ramp_done_out,
    input  wire logic [rrrc_pkg::NUM_CONV-1:0]       conv_off_in,
    output logic      [rrrc_pkg::NUM_CONV-1:0]       restart_ok_out,
    output logic      [rrrc_pkg::NUM_CONV-1:0]       freq_high_out
);

    rrrc_pkg::rrrc_state_t s_r;
    rrrc_pkg::rrrc_state_t s_nxt;
    logic                  tick;
    logic [rrrc_pkg::NUM_RAMPS-1:0][1:0] rate_code;
    logic [rrrc_pkg::NUM_CONV-1:0][1:0]  wait_code;

    // per-step interval in microseconds for a rate code
    function automatic logic [6:0] step_us(input logic [1:0] code);
        case (code)
            2'h0:    step_us = rrrc_pkg::STEP_10_US;
            2'h1:    step_us = rrrc_pkg::STEP_20_US;
            2'h2:    step_us = rrrc_pkg::STEP_40_US;
            default: step_us = rrrc_pkg::STEP_100_US;
        endcase
    endfunction

    // hold-off length in microseconds for a wait code; code 3 gives zero
    function automatic logic [15:0] hold_us(input logic [1:0] code);
        case (code)
            2'h0:    hold_us = HOLD_50MS_US;
            2'h1:    hold_us = HOLD_20MS_US;
            2'h2:    hold_us = HOLD_10MS_US;
            default: hold_us = 16'h0000;
        endcase
    endfunction

    // field extraction; the one-bit rates only reach the 10/20 us codes
    always_comb begin
        rate_code[3] = s_r.regs.ramp[rrrc_pkg::RATE_FOUR_LSB +: 2];         // [R01]
        rate_code[2] = s_r.regs.ramp[rrrc_pkg::RATE_THREE_LSB +: 2];        // [R02]
        rate_code[1] = {1'b0, s_r.regs.ramp[rrrc_pkg::RATE_TWO_BIT]};      // [R03]
        rate_code[0] = {1'b0, s_r.regs.ramp[rrrc_pkg::RATE_ONE_BIT]};      // [R04]
        wait_code[1] = s_r.regs.hold_off[rrrc_pkg::WAIT_BUCK_LSB +: 2];
        wait_code[0] = s_r.regs.hold_off[rrrc_pkg::WAIT_BB_LSB +: 2];
    end

    // 1 us tick shared by ramps and hold-off timers; divider count kept as a parameter so a full ramp fits a short run
    assign tick = (s_r.tick_cnt == TICK_DIV - 7'h01);

    // next-state logic for the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick_cnt = tick ? 7'h00 : s_r.tick_cnt + 7'h01;

        // register writes; masking keeps reserved bits at zero
        if (reg_wr_in) begin
            case (reg_addr_in)
                rrrc_pkg::ADDR_RAMP_RATE: s_nxt.regs.ramp = reg_wdata_in & rrrc_pkg::MASK_RAMP_RATE;     // [R11]
                rrrc_pkg::ADDR_FREQ_SEL:  s_nxt.regs.freq = reg_wdata_in & rrrc_pkg::MASK_FREQ_SEL;      // [R11]
                rrrc_pkg::ADDR_HOLD_OFF:  s_nxt.regs.hold_off = reg_wdata_in & rrrc_pkg::MASK_HOLD_OFF;  // [R11]
                default: ;
            endcase
        end

        // registered read; unmapped addresses read zero
        case (reg_addr_in)
            rrrc_pkg::ADDR_RAMP_RATE: s_nxt.rd_data = s_r.regs.ramp;
            rrrc_pkg::ADDR_FREQ_SEL:  s_nxt.rd_data = s_r.regs.freq;
            rrrc_pkg::ADDR_HOLD_OFF:  s_nxt.rd_data = s_r.regs.hold_off;
            default:                  s_nxt.rd_data = rrrc_pkg::RESET_REG;
        endcase

        // soft-start sequencers; a rate change mid-ramp applies to the step in progress
        for (int i = 0; i < rrrc_pkg::NUM_RAMPS; i++) begin
            if (ramp_start_in[i]) begin
                s_nxt.ramp[i].st = rrrc_pkg::RRRC_RAMP;
                s_nxt.ramp[i].ivl = 7'h00;
                s_nxt.ramp[i].level = 8'h00;
            end else begin
                case (s_r.ramp[i].st)
                    rrrc_pkg::RRRC_RAMP: begin
                        if (tick) begin
                            if (s_r.ramp[i].ivl >= step_us(rate_code[i]) - 7'h01) begin    // [R12]
                                s_nxt.ramp[i].ivl = 7'h00;
                                s_nxt.ramp[i].level = s_r.ramp[i].level + 8'h01;        // [R12]
                                if (s_r.ramp[i].level == rrrc_pkg::RAMP_STEPS - 8'h01) begin
                                    s_nxt.ramp[i].st = rrrc_pkg::RRRC_DONE;              // [R12]
                                end
                            end else begin
                                s_nxt.ramp[i].ivl = s_r.ramp[i].ivl + 7'h01;
                            end
                        end
                    end
                    rrrc_pkg::RRRC_IDLE: ;
                    rrrc_pkg::RRRC_DONE: ;
                    default: s_nxt.ramp[i].st = rrrc_pkg::RRRC_IDLE;
                endcase
            end
        end

        // discharge hold-off: loaded when the converter turns off, counts down in us
        for (int c = 0; c < rrrc_pkg::NUM_CONV; c++) begin
            if (conv_off_in[c]) begin
                s_nxt.wait_cnt[c] = hold_us(wait_code[c]);                      // [R07] [R08]
            end else if (tick && s_r.wait_cnt[c] != 16'h0000) begin
                s_nxt.wait_cnt[c] = s_r.wait_cnt[c] - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_r <= '0;
            for (int i = 0; i < rrrc_pkg::NUM_RAMPS; i++) begin
                s_r.ramp[i].st <= rrrc_pkg::RRRC_IDLE;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign reg_rd_data_out = s_r.rd_data;
    assign freq_high_out[1] = s_r.regs.freq[rrrc_pkg::FREQ_BUCK_BIT];  // [R05]
    assign freq_high_out[0] = s_r.regs.freq[rrrc_pkg::FREQ_BB_BIT];    // [R06]

    // per-channel status; code 3 bypasses the timer even if it was mid-count
    generate
        for (genvar g = 0; g < rrrc_pkg::NUM_RAMPS; g++) begin : g_ramp
            assign ramp_level_out[g] = s_r.ramp[g].level;
            assign ramp_done_out[g] = (s_r.ramp[g].st == rrrc_pkg::RRRC_DONE);
        end
        for (genvar c = 0; c < rrrc_pkg::NUM_CONV; c++) begin : g_conv
            assign restart_ok_out[c] = (wait_code[c] == rrrc_pkg::WAIT_CODE_NONE)     // [R09]
                                     || (s_r.wait_cnt[c] == 16'h0000);            // [R07] [R08]
        end
    endgenerate

endmodule

// ---- src/rrrc_pkg.sv ----
// package: register map, field layout, timing constants and types for the ramp/restart block
package rrrc_pkg;

    // register addresses on the serial register port
    localparam logic [9:0] ADDR_RAMP_RATE = 10'h202;
    localparam logic [9:0] ADDR_FREQ_SEL  = 10'h203;
    localparam logic [9:0] ADDR_HOLD_OFF  = 10'h204;

    // writable bit masks; everything else is reserved
    localparam logic [7:0] MASK_RAMP_RATE = 8'hf5;
    localparam logic [7:0] MASK_FREQ_SEL  = 8'h11;
    localparam logic [7:0] MASK_HOLD_OFF  = 8'h0f;
    localparam logic [7:0] RESET_REG      = 8'h00;

    // field positions
    localparam int RATE_FOUR_LSB   = 6;
    localparam int RATE_THREE_LSB  = 4;
    localparam int RATE_TWO_BIT    = 2;
    localparam int RATE_ONE_BIT    = 0;
    localparam int FREQ_BUCK_BIT   = 4;
    localparam int FREQ_BB_BIT     = 0;
    localparam int WAIT_BUCK_LSB   = 2;
    localparam int WAIT_BB_LSB     = 0;

    // channel counts
    localparam int NUM_RAMPS = 4;
    localparam int NUM_CONV  = 2;

    // time base: a 1 us tick from the 125 MHz clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS       = 1000;
    localparam logic [6:0] TICK_CYCLES = 7'(TICK_NS / CLK_PERIOD_NS);

    // soft-start: 128 steps, per-step interval in microseconds
    localparam logic [7:0] RAMP_STEPS = 8'h80;
    localparam logic [6:0] STEP_10_US  = 7'h0a;
    localparam logic [6:0] STEP_20_US  = 7'h14;
    localparam logic [6:0] STEP_40_US  = 7'h28;
    localparam logic [6:0] STEP_100_US = 7'h64;

    // discharge hold-off code that means no wait at all
    localparam logic [1:0] WAIT_CODE_NONE = 2'h3;

    // ramp sequencer states, one-hot
    typedef enum logic [2:0] {
        RRRC_IDLE = 3'b001,
        RRRC_RAMP = 3'b010,
        RRRC_DONE = 3'b100
    } rrrc_ramp_st_t;

    // one soft-start channel
    typedef struct packed {
        rrrc_ramp_st_t st;
        logic [6:0]    ivl;
        logic [7:0]    level;
    } rrrc_ramp_t;

    // the three configuration registers
    typedef struct packed {
        logic [7:0] hold_off;
        logic [7:0] freq;
        logic [7:0] ramp;
    } rrrc_regs_t;

    // all state of the block
    typedef struct packed {
        rrrc_regs_t                  regs;
        logic [7:0]                  rd_data;
        logic [6:0]                  tick_cnt;
        rrrc_ramp_t [NUM_RAMPS-1:0]  ramp;
        logic [NUM_CONV-1:0][15:0]   wait_cnt;
    } rrrc_state_t;

endpackage

// ---- test/rrrc_top_asserts.sv ----
// checker: port-level properties of rrrc_top
module rrrc_asserts (
    input wire logic            clk_in,
    input wire logic            reset_in,
    input wire logic [9:0]      reg_addr_in,
    input wire logic            reg_wr_in,
    input wire logic [7:0]      reg_wdata_in,
    input wire logic [7:0]      reg_rd_data_out,
    input wire logic [3:0]      ramp_start_in,
    input wire logic [3:0][7:0] ramp_level_out,
    input wire logic [3:0]      ramp_done_out,
    input wire logic [1:0]      conv_off_in,
    input wire logic [1:0]      restart_ok_out,
    input wire logic [1:0]      freq_high_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold_r;
    logic [7:0] resv;
    // shadow of the hold-off codes, the checker sees no registers
    always_ff @(posedge clk_in) begin
        if (reset_in) hold_r <= 4'h0;
        else if (reg_wr_in && reg_addr_in == 10'h204) hold_r <= reg_wdata_in[3:0];
    end
    // bits that must read zero; unmapped places read zero whole
    always_comb resv = reg_addr_in == 10'h202 ? 8'h0a : reg_addr_in == 10'h203 ? 8'hee
                     : reg_addr_in == 10'h204 ? 8'hf0 : 8'hff;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_freq_follows:
        assert property (reg_wr_in && reg_addr_in == 10'h203 |=> freq_high_out[1] == $past(reg_wdata_in[4])
            && freq_high_out[0] == $past(reg_wdata_in[0])) else $error("freq select");
    a_resv_zero:
        assert property (resv != 8'h00 |=> (reg_rd_data_out & $past(resv)) == 8'h00) else $error("reserved bits");
    a_start_clears:
        assert property (ramp_start_in[2] |=> ramp_level_out[2] == 8'h00 && !ramp_done_out[2]) else $error("start");
    a_step_one:
        assert property ($changed(ramp_level_out[3]) && !$past(ramp_start_in[3])
            |-> ramp_level_out[3] == $past(ramp_level_out[3]) + 8'h01) else $error("step size");
    a_level_cap:
        assert property (ramp_level_out[0] <= 8'h80) else $error("level cap");
    a_done_early:
        assert property (ramp_level_out[1] != 8'h80 |-> !ramp_done_out[1]) else $error("done early");
    a_hold_arms:
        assert property (conv_off_in[0] && hold_r[1:0] != 2'h3 |=> !restart_ok_out[0] [*2]) else $error("hold");
    a_hold_none:
        assert property (hold_r[3:2] == 2'h3 |-> restart_ok_out[1]) else $error("no wait");
endmodule
bind rrrc_top rrrc_asserts u_chk (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_data_out(reg_rd_data_out),
    .ramp_start_in(ramp_start_in), .ramp_level_out(ramp_level_out), .ramp_done_out(ramp_done_out),
    .conv_off_in(conv_off_in), .restart_ok_out(restart_ok_out), .freq_high_out(freq_high_out));

// ---- test/test_rrrc_top.sv ----
// bench: registers, ramp intervals and restart hold-off of rrrc_top
module test_rrrc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] H50 = 16'h0032, H20 = 16'h0014, H10 = 16'h000a;
    localparam int          TK  = 8;
    logic            clk_in, reset_in, reg_wr_in;
    logic [9:0]      reg_addr_in;
    logic [7:0]      reg_wdata_in, reg_rd_data_out;
    logic [3:0]      ramp_start_in, ramp_done_out;
    logic [3:0][7:0] ramp_level_out;
    logic [1:0]      conv_off_in, restart_ok_out, freq_high_out;
    int              fails = 0, checked = 0, cyc = 0;
    // small hold-off counts and a fast 1 us tick keep the run short
    rrrc_top #(.HOLD_50MS_US(H50), .HOLD_20MS_US(H20), .HOLD_10MS_US(H10), .TICK_DIV(7'(TK))) DUT (
        .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rd_data_out(reg_rd_data_out), .ramp_start_in(ramp_start_in),
        .ramp_level_out(ramp_level_out), .ramp_done_out(ramp_done_out), .conv_off_in(conv_off_in),
        .restart_ok_out(restart_ok_out), .freq_high_out(freq_high_out));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge clk_in) reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk_in) reg_addr_in <= a;
        repeat (2) @(posedge clk_in);
        #1 chk("read data", exp, reg_rd_data_out);
    endtask
    // reset values, masked write-back, unmapped place, frequency bits
    task automatic t_regs;
        logic [9:0] a[4] = '{10'h202, 10'h203, 10'h204, 10'h205};
        logic [7:0] m[4] = '{8'hf5, 8'h11, 8'h0f, 8'h00};
        for (int i = 0; i < 4; i++) rd(a[i], 8'h00);
        for (int i = 0; i < 4; i++) wr(a[i], 8'hff);
        for (int i = 0; i < 4; i++) rd(a[i], m[i]);
        chk("freq", 16'h0003, freq_high_out);
        wr(10'h203, 8'h10);
        #1 chk("freq", 16'h0002, freq_high_out);
    endtask
    function automatic int step_us(int i, logic [7:0] c);
        int tab[4] = '{10, 20, 40, 100};
        case (i)
            3: return tab[c[7:6]];
            2: return tab[c[5:4]];
            1: return c[2] ? 20 : 10;
            default: return c[0] ? 20 : 10;
        endcase
    endfunction
    // second step measured, the first one may be short by tick phase
    task automatic t_ramp(input logic [7:0] c);
        int t1[4], t2[4];
        wr(10'h202, c);
        @(posedge clk_in) ramp_start_in <= 4'hf;
        @(posedge clk_in) ramp_start_in <= 4'h0;
        for (int n = 0; n < 26000 && !(t2[0] && t2[1] && t2[2] && t2[3]); n++) begin
            @(posedge clk_in) #1;
            for (int i = 0; i < 4; i++) begin
                if (ramp_level_out[i] === 8'h01 && t1[i] == 0) t1[i] = cyc;
                if (ramp_level_out[i] === 8'h02 && t2[i] == 0) t2[i] = cyc;
            end
        end
        for (int i = 0; i < 4; i++) chk("step", 16'(step_us(i, c) * TK), 16'(t2[i] - t1[i]));
    endtask
    // full ramp at 10 us a step: 127 steps at 2 us before the full ramp time, then done and held at 128
    task automatic t_done;
        wr(10'h202, 8'h00);
        @(posedge clk_in) ramp_start_in <= 4'hf;
        @(posedge clk_in) ramp_start_in <= 4'h0;
        repeat ((128 * 10 - 2) * TK) @(posedge clk_in);
        #1 chk("done", 16'h0000, ramp_done_out);
        for (int i = 0; i < 4; i++) chk("level", 16'h007f, ramp_level_out[i]);
        repeat (12 * TK) @(posedge clk_in);
        #1 chk("done", 16'h000f, ramp_done_out);
        for (int i = 0; i < 4; i++) chk("level", 16'h0080, ramp_level_out[i]);
    endtask
    // both converters switched off, low time of each restart permit
    task automatic t_hold(input logic [3:0] c);
        int lo[2], n_us;
        int us[4] = '{H50, H20, H10, 0};
        wr(10'h204, {4'h0, c});
        @(posedge clk_in) conv_off_in <= 2'h3;
        @(posedge clk_in) conv_off_in <= 2'h0;
        for (int n = 0; n < 7000; n++) begin
            #1 for (int i = 0; i < 2; i++) lo[i] += (restart_ok_out[i] === 1'b0);
            @(posedge clk_in);
        end
        for (int i = 0; i < 2; i++) begin
            n_us = us[c[2*i +: 2]];
            chk("hold", 16'h0001, 16'(lo[i] >= (n_us - 1) * TK && lo[i] <= n_us * TK + 1));
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // cycle ceiling cuts a hang short
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {reset_in, reg_wr_in, reg_addr_in, reg_wdata_in, ramp_start_in, conv_off_in} = {1'b1, 25'h0};
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_ramp(8'he4);
        t_ramp(8'h11);
        t_ramp(8'hba);
        t_ramp(8'h44);
        t_done();
        t_hold(4'h9);
        t_hold(4'hc);
        @(posedge clk_in) reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(10'h204, 8'h00);
        chk("level", 16'h0000, ramp_level_out[3]);
        chk("done", 16'h0000, ramp_done_out);
        chk("freq", 16'h0000, freq_high_out);
        tally_and_finish();
    end
endmodule
